// ==== afc_autoconfig_properties.sv ====
// Concurrent checks for the input mode auto-configuration bank
`timescale 1ns/1ps
`include "afc_defs.svh"
module afc_autoconfig_properties (
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [7:0]  chipMiscCfg,
  input wire logic [7:0]  frontEndCtlOne,
  input wire logic [7:0]  frontEndCtlTwo,
  input wire logic [7:0]  frontEndCtlThree,
  input wire logic        secondConvChanThree
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  wire        modeWr = psel && penable && pready && pwrite && paddr == {`AFC_IDX_VMODE_TWO, 2'b00};
  logic       autoHit;
  logic [1:0] lastMode;
  // Registered so the field checks look at the cycle after the commit
  always_ff @(posedge clk_sys) begin
    autoHit  <= !reset && modeWr && !chipMiscCfg[`AFC_BIT_AUTO_DIS];
    lastMode <= pwdata[2:1];
  end
  a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("ready missing after one wait state");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_alt_from_mode: assert property (autoHit |-> chipMiscCfg[2] == lastMode[1])
    else $error("alternate sampling bit wrong after format write");
  a_fe_three_auto: assert property (autoHit |-> frontEndCtlThree[4:3] ==
    {&lastMode, lastMode[1]} && frontEndCtlThree[1:0] == {2{&lastMode}})
    else $error("sag or clamp bits wrong after format write");
  a_amp_three_auto: assert property (autoHit |-> frontEndCtlTwo[0] == !lastMode[0])
    else $error("channel three amp pick wrong");
  a_fe_one_auto: assert property (autoHit |-> frontEndCtlOne[6:4] ==
    {lastMode == 2'h0, {2{&lastMode}}})
    else $error("amp pick or narrow band bits wrong");
  a_off_keeps: assert property (modeWr && chipMiscCfg[4] |=> $stable(frontEndCtlThree)
    && $stable(frontEndCtlOne) && $stable(frontEndCtlTwo))
    else $error("fields changed with auto setup off");
  a_alt_toggles: assert property (chipMiscCfg[2] && $past(chipMiscCfg[2]) |=>
    secondConvChanThree != $past(secondConvChanThree))
    else $error("channel did not alternate");
  a_static_pick: assert property (!chipMiscCfg[2] && !$past(chipMiscCfg[2]) |=>
    secondConvChanThree == $past(chipMiscCfg[1]))
    else $error("static channel pick not followed");
endmodule
bind afc_input_mode_autoconfig afc_autoconfig_properties afc_autoconfig_properties_i (
  .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .chipMiscCfg(chipMiscCfg),
  .frontEndCtlOne(frontEndCtlOne), .frontEndCtlTwo(frontEndCtlTwo),
  .frontEndCtlThree(frontEndCtlThree), .secondConvChanThree(secondConvChanThree));

// ==== afc_defs.svh ====
// Constants for the front-end input mode auto-configuration register bank
// Summary of operation
// - Input format field bits 2:1: 00 composite, 01 Y/C, 10 Y/C/A, 11 component.
// - Writing the format field updates all dependent fields at once when enabled.
// - Software may overwrite any auto-set field; its value then stays.
// - Each new format write reapplies auto values, discarding earlier overrides.
// - Auto setup enabled after reset; suppressed while chip config bit 4 is 1.
// - Reset: format reads 00 and dependent fields hold composite values.
// - Alternate sampling bit 2 set for Y/C/A and component, else cleared.
// - In alternate mode second converter swaps channel 2 and 3 every sample.
// - Sag comp channel 3 only in component; channel 2 in Y/C/A and component.
// - Clamp enables for channels 3 and 2 set only in component mode.
// - Channel 3 amp pick set in composite and Y/C/A, cleared otherwise.
// - Channel 1 amp pick set only in composite mode.
// - Narrow band bits for channels 3 and 2 set only in component mode.
// - With auto setup on, streams route to converters by the format table.
// - Power control register powers down second converter and its amplifiers.
// - Without alternate sampling, channel pick bit statically selects channel 2 or 3.
`ifndef AFC_DEFS_SVH
`define AFC_DEFS_SVH
`define AFC_IDX_CHIP_MISC   14'h0102
`define AFC_IDX_FE_ONE      14'h0104
`define AFC_IDX_FE_TWO      14'h0105
`define AFC_IDX_FE_THREE    14'h0106
`define AFC_IDX_POWER_ONE   14'h0130
`define AFC_IDX_VMODE_TWO   14'h0401
`define AFC_BIT_CHAN_PICK   1
`define AFC_BIT_ALTERNATE   2
`define AFC_BIT_AUTO_DIS    4
`define AFC_BIT_SWAP        5
`define AFC_BIT_SAG_THREE   4
`define AFC_BIT_SAG_TWO     3
`define AFC_BIT_CLAMP_THREE 1
`define AFC_BIT_CLAMP_TWO   0
`define AFC_BIT_AMP_THREE   0
`define AFC_BIT_AMP_ONE     6
`define AFC_BIT_NB_THREE    5
`define AFC_BIT_NB_TWO      4
`define AFC_BIT_PD_CONV     0
`define AFC_BIT_PD_AMPS     1
`define AFC_MODE_HI         2
`define AFC_MODE_LO         1
`define AFC_RST_CHIP_MISC   8'h00
`define AFC_RST_FE_ONE      8'h40
`define AFC_RST_FE_TWO      8'h01
`define AFC_RST_FE_THREE    8'h00
`define AFC_RST_POWER_ONE   8'h00
`define AFC_RST_VMODE_TWO   8'h00
`define AFC_MASK_CHIP_MISC  8'h04
`define AFC_MASK_FE_ONE     8'h70
`define AFC_MASK_FE_TWO     8'h01
`define AFC_MASK_FE_THREE   8'h1B
`endif

// ==== afc_input_mode_autoconfig.sv ====
// Register bank with input mode auto-configuration of the analog front end
`timescale 1ns/1ps
`include "afc_defs.svh"
module afc_input_mode_autoconfig (
  input  wire logic                 clk_sys,
  input  wire logic                 reset,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [15:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic [31:0]               prdata,
  output logic                      pslverr,
  output logic [7:0]                chipMiscCfg,
  output logic [7:0]                frontEndCtlOne,
  output logic [7:0]                frontEndCtlTwo,
  output logic [7:0]                frontEndCtlThree,
  output logic [7:0]                powerCtlOne,
  output logic [7:0]                videoModeCtlTwo,
  output logic                      secondConvChanThree,
  output logic                      secondConvPowerDown,
  output logic                      chromaAmpPowerDown,
  output afc_pkg::afc_stream_t      firstConvStream,
  output afc_pkg::afc_stream_t      secondConvStream
);

  // Auto values for one register under a given mode
  function automatic logic [7:0] autoChipMisc(
    input logic [1:0] mode
  );
    logic [7:0] v;
    v = 8'h00;
    v[`AFC_BIT_ALTERNATE] = mode[1];
    return v;
  endfunction

  function automatic logic [7:0] autoFeOne(
    input logic [1:0] mode
  );
    logic [7:0] v;
    v = 8'h00;
    v[`AFC_BIT_AMP_ONE]   = (mode == 2'h0);
    v[`AFC_BIT_NB_THREE]  = (mode == 2'h3);
    v[`AFC_BIT_NB_TWO]    = (mode == 2'h3);
    return v;
  endfunction

  function automatic logic [7:0] autoFeTwo(
    input logic [1:0] mode
  );
    logic [7:0] v;
    v = 8'h00;
    v[`AFC_BIT_AMP_THREE] = ~mode[0];
    return v;
  endfunction

  function automatic logic [7:0] autoFeThree(
    input logic [1:0] mode
  );
    logic [7:0] v;
    v = 8'h00;
    v[`AFC_BIT_SAG_THREE]   = (mode == 2'h3);
    v[`AFC_BIT_SAG_TWO]     = mode[1];
    v[`AFC_BIT_CLAMP_THREE] = (mode == 2'h3);
    v[`AFC_BIT_CLAMP_TWO]   = (mode == 2'h3);
    return v;
  endfunction

  // Next value of one register: write, auto merge, or hold
  function automatic logic [7:0] regNext(
    input logic [7:0] cur,
    input logic       wr,
    input logic [7:0] wdat,
    input logic       apply,
    input logic [7:0] mask,
    input logic [7:0] autoVal
  );
    logic [7:0] v;
    v = cur;
    if (wr) begin
      v = wdat;
    end else if (apply) begin
      v = (cur & ~mask) | (autoVal & mask);
    end
    return v;
  endfunction

  // Stream routing, first converter in the upper three bits
  function automatic logic [5:0] routeFor(
    input logic [1:0] mode
  );
    logic [5:0] v;
    case (mode)
      2'h0: v = {afc_pkg::AFC_STR_CVBS, afc_pkg::AFC_STR_AUDIO};
      2'h1: v = {afc_pkg::AFC_STR_LUMA, afc_pkg::AFC_STR_CHROMA};
      2'h2: v = {afc_pkg::AFC_STR_LUMA, afc_pkg::AFC_STR_CH_AUD};
      2'h3: v = {afc_pkg::AFC_STR_LUMA, afc_pkg::AFC_STR_PBPR};
      default: v = {afc_pkg::AFC_STR_CVBS, afc_pkg::AFC_STR_AUDIO};
    endcase
    return v;
  endfunction

  logic [7:0]  chipMisc_reg;
  logic [7:0]  chipMisc_next;
  logic [7:0]  feOne_reg;
  logic [7:0]  feOne_next;
  logic [7:0]  feTwo_reg;
  logic [7:0]  feTwo_next;
  logic [7:0]  feThree_reg;
  logic [7:0]  feThree_next;
  logic [7:0]  powerOne_reg;
  logic [7:0]  powerOne_next;
  logic [7:0]  vmodeTwo_reg;
  logic [7:0]  vmodeTwo_next;
  logic        pready_reg;
  logic        pready_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic        pslverr_reg;
  logic        pslverr_next;
  logic        chanThree_reg;
  logic        chanThree_next;
  logic [5:0]  route_reg;
  logic [5:0]  route_next;

  // Address decode
  wire logic [13:0] regIndex;
  wire logic        aligned;
  wire logic        hitChip;
  wire logic        hitFeOne;
  wire logic        hitFeTwo;
  wire logic        hitFeThree;
  wire logic        hitPower;
  wire logic        hitVmode;
  wire logic        mapped;
  wire logic        access;
  wire logic        commit;
  wire logic        wrCommit;
  wire logic [7:0]  wdat;
  wire logic [7:0]  readByte;
  wire logic        autoOn;
  wire logic        applyAuto;
  wire logic [1:0]  newMode;
  wire logic [1:0]  curMode;
  wire logic [5:0]  autoRoute;
  wire logic [5:0]  swapRoute;

  assign regIndex   = paddr[15:2];
  assign aligned    = (paddr[1:0] == 2'h0);
  assign hitChip    = aligned && (regIndex == `AFC_IDX_CHIP_MISC);
  assign hitFeOne   = aligned && (regIndex == `AFC_IDX_FE_ONE);
  assign hitFeTwo   = aligned && (regIndex == `AFC_IDX_FE_TWO);
  assign hitFeThree = aligned && (regIndex == `AFC_IDX_FE_THREE);
  assign hitPower   = aligned && (regIndex == `AFC_IDX_POWER_ONE);
  assign hitVmode   = aligned && (regIndex == `AFC_IDX_VMODE_TWO);
  assign mapped     = hitChip | hitFeOne | hitFeTwo | hitFeThree
                    | hitPower | hitVmode;

  // One wait state; writes land only on the edge that completes the transfer
  assign access   = psel & penable;
  assign commit   = access & pready_reg;
  assign wrCommit = commit & pwrite & mapped;
  assign wdat     = pwdata[7:0];

  // Upper 24 bits of every register read as zero
  assign readByte = hitChip    ? chipMisc_reg :
                    hitFeOne   ? feOne_reg    :
                    hitFeTwo   ? feTwo_reg    :
                    hitFeThree ? feThree_reg  :
                    hitPower   ? powerOne_reg :
                    hitVmode   ? vmodeTwo_reg : 8'h00;

  assign autoOn    = ~chipMisc_reg[`AFC_BIT_AUTO_DIS];
  assign applyAuto = wrCommit & hitVmode & autoOn;
  assign newMode   = wdat[`AFC_MODE_HI:`AFC_MODE_LO];
  assign curMode   = vmodeTwo_reg[`AFC_MODE_HI:`AFC_MODE_LO];

  assign pready_next  = access & ~pready_reg;
  assign pslverr_next = access & ~pready_reg & ~mapped;
  assign prdata_next  = (access & ~pready_reg & ~pwrite)
                        ? {24'h000000, readByte} : prdata_reg;

  // Auto fields follow in the same edge as the format write
  assign chipMisc_next = regNext(chipMisc_reg, wrCommit & hitChip, wdat,
                                 applyAuto, `AFC_MASK_CHIP_MISC,
                                 autoChipMisc(newMode));
  assign feOne_next    = regNext(feOne_reg, wrCommit & hitFeOne, wdat,
                                 applyAuto, `AFC_MASK_FE_ONE,
                                 autoFeOne(newMode));
  assign feTwo_next    = regNext(feTwo_reg, wrCommit & hitFeTwo, wdat,
                                 applyAuto, `AFC_MASK_FE_TWO,
                                 autoFeTwo(newMode));
  assign feThree_next  = regNext(feThree_reg, wrCommit & hitFeThree, wdat,
                                 applyAuto, `AFC_MASK_FE_THREE,
                                 autoFeThree(newMode));
  assign powerOne_next = regNext(powerOne_reg, wrCommit & hitPower, wdat,
                                 1'b0, 8'h00, 8'h00);
  assign vmodeTwo_next = regNext(vmodeTwo_reg, wrCommit & hitVmode, wdat,
                                 1'b0, 8'h00, 8'h00);

  // Channel pick toggles every sample clock in alternate mode
  assign chanThree_next = chipMisc_reg[`AFC_BIT_ALTERNATE]
                          ? ~chanThree_reg
                          : chipMisc_reg[`AFC_BIT_CHAN_PICK];

  // Swap honoured only with auto setup off, else the table is imposed
  assign autoRoute  = routeFor(curMode);
  assign swapRoute  = {autoRoute[2:0], autoRoute[5:3]};
  assign route_next = (~autoOn & chipMisc_reg[`AFC_BIT_SWAP])
                      ? swapRoute : autoRoute;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      chipMisc_reg <= `AFC_RST_CHIP_MISC;
      feOne_reg    <= `AFC_RST_FE_ONE;
      feTwo_reg    <= `AFC_RST_FE_TWO;
      feThree_reg  <= `AFC_RST_FE_THREE;
      powerOne_reg <= `AFC_RST_POWER_ONE;
      vmodeTwo_reg <= `AFC_RST_VMODE_TWO;
    end else begin
      chipMisc_reg <= chipMisc_next;
      feOne_reg    <= feOne_next;
      feTwo_reg    <= feTwo_next;
      feThree_reg  <= feThree_next;
      powerOne_reg <= powerOne_next;
      vmodeTwo_reg <= vmodeTwo_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h00000000;
    end else begin
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg  <= prdata_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      chanThree_reg <= 1'b0;
      route_reg     <= {afc_pkg::AFC_STR_CVBS, afc_pkg::AFC_STR_AUDIO};
    end else begin
      chanThree_reg <= chanThree_next;
      route_reg     <= route_next;
    end
  end

  assign pready              = pready_reg;
  assign pslverr             = pslverr_reg;
  assign prdata              = prdata_reg;
  assign chipMiscCfg         = chipMisc_reg;
  assign frontEndCtlOne      = feOne_reg;
  assign frontEndCtlTwo      = feTwo_reg;
  assign frontEndCtlThree    = feThree_reg;
  assign powerCtlOne         = powerOne_reg;
  assign videoModeCtlTwo     = vmodeTwo_reg;
  assign secondConvChanThree = chanThree_reg;
  assign secondConvPowerDown = powerOne_reg[`AFC_BIT_PD_CONV];
  assign chromaAmpPowerDown  = powerOne_reg[`AFC_BIT_PD_AMPS];
  assign firstConvStream     = afc_pkg::afc_stream_t'(route_reg[5:3]);
  assign secondConvStream    = afc_pkg::afc_stream_t'(route_reg[2:0]);

endmodule

// ==== afc_input_mode_autoconfig_bench.sv ====
// Register-level bench for the input mode auto-configuration bank
`timescale 1ns/1ps
`include "afc_defs.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module afc_input_mode_autoconfig_bench;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        pready, pslverr, er;
  logic [31:0] prdata, rd;
  logic [7:0]  chipMiscCfg, frontEndCtlOne, frontEndCtlTwo, frontEndCtlThree;
  logic [7:0]  powerCtlOne, videoModeCtlTwo;
  logic        secondConvChanThree, secondConvPowerDown, chromaAmpPowerDown;
  afc_pkg::afc_stream_t firstConvStream, secondConvStream;
  afc_pkg::afc_stream_t secExp [4] = '{afc_pkg::AFC_STR_AUDIO, afc_pkg::AFC_STR_CHROMA,
                                       afc_pkg::AFC_STR_CH_AUD, afc_pkg::AFC_STR_PBPR};
  int          fail_count = 0;
  int          tests_run = 0;
  int          cycles = 0;
  always #50 clk_sys = ~clk_sys;
  afc_input_mode_autoconfig afc_input_mode_autoconfig_i (
    .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .chipMiscCfg(chipMiscCfg), .frontEndCtlOne(frontEndCtlOne),
    .frontEndCtlTwo(frontEndCtlTwo), .frontEndCtlThree(frontEndCtlThree),
    .powerCtlOne(powerCtlOne), .videoModeCtlTwo(videoModeCtlTwo),
    .secondConvChanThree(secondConvChanThree), .secondConvPowerDown(secondConvPowerDown),
    .chromaAmpPowerDown(chromaAmpPowerDown), .firstConvStream(firstConvStream),
    .secondConvStream(secondConvStream));
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Whole run needs a few hundred cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      $display("mismatch at %0t: run timed out", $time);
      close_out();
    end
  end
  // Idle edge at the end keeps psel from being assigned twice in one step
  task automatic xfer(input logic w, input logic [13:0] i, input logic [1:0] lo,
                      input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, lo};
    pwdata <= {24'h00_0000, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    // Sampled mid-cycle so the flop outputs are settled
    do @(negedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    @(posedge clk_sys);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [13:0] i, input logic [7:0] d);
    xfer(1'b1, i, 2'b00, d);
    `CHK(er, 1'b0)
  endtask
  task automatic rdc(input logic [13:0] i, input logic [7:0] e);
    xfer(1'b0, i, 2'b00, 8'h00);
    `CHK({er, rd}, {1'b0, 24'h00_0000, e})
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    rdc(`AFC_IDX_CHIP_MISC, 8'h00);
    rdc(`AFC_IDX_FE_ONE, 8'h40);
    rdc(`AFC_IDX_FE_TWO, 8'h01);
    rdc(`AFC_IDX_FE_THREE, 8'h00);
    rdc(`AFC_IDX_POWER_ONE, 8'h00);
    rdc(`AFC_IDX_VMODE_TWO, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr(`AFC_IDX_VMODE_TWO, 8'(m << 1));
      rdc(`AFC_IDX_CHIP_MISC, {5'h00, m[1], 2'h0});
      rdc(`AFC_IDX_FE_ONE, {1'b0, m == 0, {2{m == 3}}, 4'h0});
      rdc(`AFC_IDX_FE_TWO, {7'h00, !m[0]});
      rdc(`AFC_IDX_FE_THREE, {3'h0, m == 3, m >= 2, 1'b0, {2{m == 3}}});
      `CHK(firstConvStream, m == 0 ? afc_pkg::AFC_STR_CVBS : afc_pkg::AFC_STR_LUMA)
      `CHK(secondConvStream, secExp[m])
      rdc(`AFC_IDX_VMODE_TWO, 8'(m << 1));
    end
    wr(`AFC_IDX_FE_THREE, 8'hE0);
    rdc(`AFC_IDX_FE_THREE, 8'hE0);
    wr(`AFC_IDX_VMODE_TWO, 8'h04);
    rdc(`AFC_IDX_FE_THREE, 8'hE8);
    wr(`AFC_IDX_CHIP_MISC, 8'h02);
    repeat (2) @(posedge clk_sys);
    `CHK(secondConvChanThree, 1'b1)
    wr(`AFC_IDX_CHIP_MISC, 8'h10);
    wr(`AFC_IDX_VMODE_TWO, 8'h06);
    rdc(`AFC_IDX_FE_THREE, 8'hE8);
    rdc(`AFC_IDX_FE_ONE, 8'h00);
    rdc(`AFC_IDX_VMODE_TWO, 8'h06);
    wr(`AFC_IDX_CHIP_MISC, 8'h30);
    repeat (2) @(posedge clk_sys);
    `CHK(firstConvStream, afc_pkg::AFC_STR_PBPR)
    `CHK(secondConvStream, afc_pkg::AFC_STR_LUMA)
    wr(`AFC_IDX_FE_TWO, 8'h06);
    rdc(`AFC_IDX_FE_TWO, 8'h06);
    wr(`AFC_IDX_POWER_ONE, 8'h03);
    `CHK({secondConvPowerDown, chromaAmpPowerDown}, 2'b11)
    xfer(1'b0, 14'h0103, 2'b00, 8'h00);
    `CHK({er, rd}, {1'b1, 32'h0000_0000})
    xfer(1'b1, `AFC_IDX_POWER_ONE, 2'b01, 8'h00);
    `CHK(er, 1'b1)
    rdc(`AFC_IDX_POWER_ONE, 8'h03);
    close_out();
  end
endmodule

// ==== afc_pkg.sv ====
// Types for the front-end input mode auto-configuration register bank
package afc_pkg;
  typedef enum logic [1:0] {
    AFC_MODE_CVBS = 2'h0,
    AFC_MODE_YC   = 2'h1,
    AFC_MODE_YCA  = 2'h2,
    AFC_MODE_YPP  = 2'h3
  } afc_mode_t;
  typedef enum logic [2:0] {
    AFC_STR_CVBS   = 3'h0,
    AFC_STR_LUMA   = 3'h1,
    AFC_STR_AUDIO  = 3'h2,
    AFC_STR_CHROMA = 3'h3,
    AFC_STR_CH_AUD = 3'h4,
    AFC_STR_PBPR   = 3'h5
  } afc_stream_t;
endpackage
